// [param_read_block.sv]
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/10ps
module param_read_block (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Requester side.
  input wire logic start_req,
  input wire logic [7:0] target_node,
  input wire logic [15:0] param_index,
  input wire logic [7:0] param_subindex,
  output logic busy,
  output logic active,
  output logic done,
  output logic error,
  output logic [15:0] fault_code,
  output logic [7:0] width_code,
  output logic [31:0] read_data,
  // Slave transfer port.
  output logic xfer_req,
  output logic [7:0] xfer_node,
  output logic [15:0] xfer_index,
  output logic [7:0] xfer_subindex,
  input wire logic xfer_ack,
  input wire logic xfer_fail,
  input wire logic [7:0] xfer_width,
  input wire logic [31:0] xfer_data,
  // Interrupt.
  output logic irq
);

  // ********************************
  // Start edge and request checks.
  // ********************************
  param_read_pkg::rd_state_t state_r;
  param_read_pkg::rd_state_t state_nxt;
  localparam int IRQ_W_L = param_read_pkg::IRQ_W;
  logic start_d_r;
  logic [IRQ_W_L-1:0] irq_stat_r;
  logic [IRQ_W_L-1:0] irq_mask_r;

  wire start_rise = start_req & ~start_d_r;
  wire start_fall = ~start_req & start_d_r;
  wire node_ok = (target_node >= param_read_pkg::NODE_MIN) &&
                 (target_node <= param_read_pkg::NODE_MAX);
  wire launch = start_rise && (state_r == param_read_pkg::ST_IDLE ||
                state_r == param_read_pkg::ST_DONE ||
                state_r == param_read_pkg::ST_ERR);

  // Byte mask for the reported width.
  function automatic logic [31:0] width_mask(input logic [7:0] w);
    case (w)
      param_read_pkg::WIDTH_BYTE: width_mask = 32'h0000_00ff;
      param_read_pkg::WIDTH_WORD: width_mask = 32'h0000_ffff;
      default: width_mask = 32'hffff_ffff;
    endcase
  endfunction : width_mask

  wire width_ok = (xfer_width == param_read_pkg::WIDTH_BYTE) ||
                  (xfer_width == param_read_pkg::WIDTH_WORD) ||
                  (xfer_width == param_read_pkg::WIDTH_DWORD);
  wire xfer_good = xfer_ack && !xfer_fail && width_ok;
  wire xfer_bad = xfer_ack && !xfer_good;
  wire done_ev = (state_r == param_read_pkg::ST_WAIT) && xfer_good;
  wire err_ev = (launch && !node_ok) ||
                ((state_r == param_read_pkg::ST_WAIT) && xfer_bad);

  // ********************************
  // Control state machine.
  // ********************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      param_read_pkg::ST_IDLE, param_read_pkg::ST_DONE,
      param_read_pkg::ST_ERR: begin
        if (launch) begin
          state_nxt = node_ok ? param_read_pkg::ST_WAIT : param_read_pkg::ST_ERR;
        end else if (start_fall && state_r == param_read_pkg::ST_ERR) begin
          state_nxt = param_read_pkg::ST_IDLE;
        end
      end
      param_read_pkg::ST_WAIT: begin
        if (xfer_good) begin
          state_nxt = param_read_pkg::ST_DONE;
        end else if (xfer_bad) begin
          state_nxt = param_read_pkg::ST_ERR;
        end
      end
      default: state_nxt = param_read_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= param_read_pkg::ST_IDLE;
      start_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      start_d_r <= start_req;
    end
  end

  // ********************************
  // Busy and active flags.
  // ********************************
  // Busy rises combinationally with a start edge to a legal node and ends with done or error.
  assign busy = (launch && node_ok) || (state_r == param_read_pkg::ST_WAIT);
  assign active = state_r == param_read_pkg::ST_WAIT;
  assign xfer_req = active;

  // ********************************
  // Sampled request and results.
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_node <= 8'h00;
      xfer_index <= 16'h0000;
      xfer_subindex <= 8'h00;
    end else if (launch) begin
      xfer_node <= target_node;
      xfer_index <= param_index;
      xfer_subindex <= param_subindex;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
      error <= 1'b0;
      fault_code <= param_read_pkg::FAULT_NONE;
      width_code <= param_read_pkg::WIDTH_NONE;
      read_data <= 32'h0000_0000;
    end else begin
      if (done_ev) begin
        done <= 1'b1;
        width_code <= xfer_width;
        read_data <= xfer_data & width_mask(xfer_width);
      end else if (err_ev) begin
        error <= 1'b1;
        done <= 1'b0;
        width_code <= param_read_pkg::WIDTH_NONE;
        read_data <= 32'h0000_0000;
        if (launch) begin
          fault_code <= param_read_pkg::FAULT_BAD_NODE;
        end else if (xfer_fail) begin
          fault_code <= param_read_pkg::FAULT_XFER;
        end else begin
          fault_code <= param_read_pkg::FAULT_BAD_WIDTH;
        end
      end else if (start_fall) begin
        done <= 1'b0;
        error <= 1'b0;
        fault_code <= param_read_pkg::FAULT_NONE;
      end
      if (launch && node_ok) begin
        done <= 1'b0;
        error <= 1'b0;
        fault_code <= param_read_pkg::FAULT_NONE;
      end
    end
  end

  // ********************************
  // APB registers and interrupt.
  // ********************************
  wire apb_wr = psel && penable && pwrite;
  wire apb_rd = psel && penable && !pwrite;
  wire [IRQ_W_L-1:0] irq_ev = {err_ev, done_ev};
  wire rd_stat = apb_rd && (paddr == param_read_pkg::OFS_IRQ_STAT);
  wire addr_ok = (paddr == param_read_pkg::OFS_STATUS) ||
                 (paddr == param_read_pkg::OFS_IRQ_STAT) ||
                 (paddr == param_read_pkg::OFS_IRQ_MASK) ||
                 (paddr == param_read_pkg::OFS_DATA) ||
                 (paddr == param_read_pkg::OFS_FAULT);

  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign irq = |(irq_stat_r & irq_mask_r);

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      param_read_pkg::OFS_STATUS: prdata = {16'h0000, width_code, 4'h0,
                                            error, done, active, busy};
      param_read_pkg::OFS_IRQ_STAT: prdata = {30'h0, irq_stat_r};
      param_read_pkg::OFS_IRQ_MASK: prdata = {30'h0, irq_mask_r};
      param_read_pkg::OFS_DATA: prdata = read_data;
      param_read_pkg::OFS_FAULT: prdata = {16'h0000, fault_code};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // A new event wins over the clear by read in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= 2'h0;
      irq_mask_r <= 2'h0;
    end else begin
      irq_stat_r <= (rd_stat ? 2'h0 : irq_stat_r) | irq_ev;
      if (apb_wr && paddr == param_read_pkg::OFS_IRQ_MASK) begin
        irq_mask_r <= pwdata[IRQ_W_L-1:0];
      end
    end
  end

  // ********************************
  // Assertions.
  // ********************************
  property p_start_edge_only;
    @(posedge pclk) disable iff (!presetn)
    (state_r != param_read_pkg::ST_WAIT && start_req && start_d_r) |=>
      state_r == $past(state_r);
  endproperty
  a_start_edge_only: assert property (p_start_edge_only)
    else $error("read started without a start edge");

  property p_sample_node;
    @(posedge pclk) disable iff (!presetn)
    (launch && node_ok) |=> (xfer_node == $past(target_node) &&
      xfer_index == $past(param_index) && xfer_subindex == $past(param_subindex));
  endproperty
  a_sample_node: assert property (p_sample_node)
    else $error("request fields not sampled at start edge");

  property p_width_valid;
    @(posedge pclk) disable iff (!presetn)
    $rose(done) |-> (width_code == param_read_pkg::WIDTH_BYTE ||
      width_code == param_read_pkg::WIDTH_WORD || width_code == param_read_pkg::WIDTH_DWORD);
  endproperty
  a_width_valid: assert property (p_width_valid)
    else $error("done with invalid width code");

  property p_busy_ends;
    @(posedge pclk) disable iff (!presetn)
    (active && (xfer_ack)) |=> !busy || launch;
  endproperty
  a_busy_ends: assert property (p_busy_ends)
    else $error("busy stays after completion");

  property p_done_hold;
    @(posedge pclk) disable iff (!presetn)
    (done && start_req && !launch) |=> done;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("done cleared while start still high");

  property p_bad_node;
    @(posedge pclk) disable iff (!presetn)
    (launch && !node_ok) |=> (error && width_code == 8'h00 && read_data == 32'h0
      && fault_code == param_read_pkg::FAULT_BAD_NODE);
  endproperty
  a_bad_node: assert property (p_bad_node)
    else $error("illegal node not reported");

  property p_err_clear;
    @(posedge pclk) disable iff (!presetn)
    (error && start_fall && !launch) |=> (!error && fault_code == 16'h0000);
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error not cleared on start fall");

  property p_fault_while_err;
    @(posedge pclk) disable iff (!presetn)
    error |-> fault_code != param_read_pkg::FAULT_NONE;
  endproperty
  a_fault_while_err: assert property (p_fault_while_err)
    else $error("error without fault code");

  property p_no_retrigger;
    @(posedge pclk) disable iff (!presetn)
    (active && !xfer_ack) |=> $stable(xfer_node) && $stable(xfer_index);
  endproperty
  a_no_retrigger: assert property (p_no_retrigger)
    else $error("request changed during busy read");

  property p_active_next;
    @(posedge pclk) disable iff (!presetn)
    (launch && node_ok) |=> active && xfer_req;
  endproperty
  a_active_next: assert property (p_active_next)
    else $error("active not raised after accepted start");

  property p_done_result;
    @(posedge pclk) disable iff (!presetn)
    $rose(done) |-> !active && (!busy || launch) &&
      width_code != param_read_pkg::WIDTH_NONE;
  endproperty
  a_done_result: assert property (p_done_result)
    else $error("done raised while still busy or without width");

  property p_done_clear;
    @(posedge pclk) disable iff (!presetn)
    (done && start_fall) |=> !done;
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("done not cleared on start fall");

  property p_data_hold;
    @(posedge pclk) disable iff (!presetn)
    (state_r == param_read_pkg::ST_DONE && !launch) |=>
      $stable(width_code) && $stable(read_data);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("result changed after completion");

  property p_data_masked;
    @(posedge pclk) disable iff (!presetn)
    $rose(done) |-> (read_data & ~width_mask(width_code)) == 32'h0000_0000;
  endproperty
  a_data_masked: assert property (p_data_masked)
    else $error("read value wider than its width code");

  property p_err_result;
    @(posedge pclk) disable iff (!presetn)
    $rose(error) |-> !active && !done && (!busy || launch);
  endproperty
  a_err_result: assert property (p_err_result)
    else $error("error raised while busy, active or done");

endmodule : param_read_block

// [param_read_pkg.sv]
package param_read_pkg;

  // Node number limits.
  localparam logic [7:0] NODE_MIN = 8'h01;
  localparam logic [7:0] NODE_MAX = 8'h7f;

  // Width codes.
  localparam logic [7:0] WIDTH_NONE = 8'h00;
  localparam logic [7:0] WIDTH_BYTE = 8'h01;
  localparam logic [7:0] WIDTH_WORD = 8'h02;
  localparam logic [7:0] WIDTH_DWORD = 8'h04;

  // Fault codes; the values are arbitrary but distinct, and nonzero except FAULT_NONE.
  localparam logic [15:0] FAULT_NONE = 16'h0000;
  localparam logic [15:0] FAULT_BAD_NODE = 16'h0001;
  localparam logic [15:0] FAULT_XFER = 16'h0002;
  localparam logic [15:0] FAULT_BAD_WIDTH = 16'h0003;

  // Register byte offsets.
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_FAULT = 8'h10;

  // Interrupt bit positions.
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam int IRQ_W = 2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_DONE,
    ST_ERR
  } rd_state_t;

endpackage : param_read_pkg

// [slave_model.sv]
`timescale 1ns/10ps
// ****************************************************************
// Slave node that answers one parameter read per request.
// ****************************************************************
module slave_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Transfer port.
  input wire logic xfer_req,
  output logic xfer_ack,
  output logic xfer_fail,
  output logic [7:0] xfer_width,
  output logic [31:0] xfer_data,
  // Answer chosen by the bench.
  input wire logic [7:0] delay,
  input wire logic [7:0] rsp_width,
  input wire logic [31:0] rsp_data,
  input wire logic rsp_fail
);
  logic [7:0] cnt_r;
  logic armed_r;
  // Idle answer lines change every cycle so that stale values never pass.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_ack <= 1'b0;
      xfer_fail <= 1'b0;
      xfer_width <= 8'h00;
      xfer_data <= 32'h0000_0000;
      cnt_r <= 8'h00;
      armed_r <= 1'b1;
    end else if (xfer_req && armed_r && cnt_r == delay) begin
      xfer_ack <= 1'b1;
      xfer_fail <= rsp_fail;
      xfer_width <= rsp_width;
      xfer_data <= rsp_data;
      armed_r <= 1'b0;
    end else begin
      xfer_ack <= 1'b0;
      xfer_fail <= ~xfer_fail;
      xfer_width <= ~xfer_width;
      xfer_data <= ~xfer_data;
      cnt_r <= xfer_req ? cnt_r + 8'h01 : 8'h00;
      armed_r <= armed_r | ~xfer_req;
    end
  end
endmodule : slave_model

// [testbench.sv]
`timescale 1ns/10ps
// ****************************************************************
// Bench for the parameter read block.
// ****************************************************************
module testbench;
  typedef struct packed {
    logic err;
    logic [15:0] fc;
    logic [7:0] w;
    logic [31:0] d;
  } exp_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, start_req, busy, active;
  logic done, error, xfer_req, xfer_ack, xfer_fail, irq, rsp_fail, done_q, err_q;
  logic [7:0] paddr, target_node, param_subindex, width_code, xfer_node, xfer_subindex;
  logic [7:0] xfer_width, delay, rsp_width;
  logic [15:0] param_index, fault_code, xfer_index;
  logic [31:0] pwdata, prdata, read_data, xfer_data, rsp_data, rd;
  integer seed;
  logic er;
  int mismatches, num_checks, i;
  exp_t exp_q[$];
  param_read_block param_read_block_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .start_req(start_req), .target_node(target_node),
    .param_index(param_index), .param_subindex(param_subindex), .busy(busy),
    .active(active), .done(done), .error(error), .fault_code(fault_code),
    .width_code(width_code), .read_data(read_data), .xfer_req(xfer_req),
    .xfer_node(xfer_node), .xfer_index(xfer_index), .xfer_subindex(xfer_subindex),
    .xfer_ack(xfer_ack), .xfer_fail(xfer_fail), .xfer_width(xfer_width),
    .xfer_data(xfer_data), .irq(irq));
  slave_model slave_model_inst (.pclk(pclk), .presetn(presetn), .xfer_req(xfer_req),
    .xfer_ack(xfer_ack), .xfer_fail(xfer_fail), .xfer_width(xfer_width),
    .xfer_data(xfer_data), .delay(delay), .rsp_width(rsp_width), .rsp_data(rsp_data),
    .rsp_fail(rsp_fail));
  always #2 pclk = ~pclk;
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      mismatches++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run(input logic [7:0] node, input logic [15:0] idx, input logic [7:0] w,
                     input logic f, input logic [7:0] dly, input logic again);
    exp_t e;
    logic [31:0] d;
    int n;
    d = $random(seed);
    e = '{1'b1, 16'h0000, 8'h00, 32'h0000_0000};
    if (node < param_read_pkg::NODE_MIN || node > param_read_pkg::NODE_MAX) begin
      e.fc = param_read_pkg::FAULT_BAD_NODE;
    end else if (f) e.fc = param_read_pkg::FAULT_XFER;
    else if (w != 8'h01 && w != 8'h02 && w != 8'h04) e.fc = param_read_pkg::FAULT_BAD_WIDTH;
    else e = '{1'b0, 16'h0000, w, w == 8'h01 ? d & 32'hff : w == 8'h02 ? d & 32'hffff : d};
    exp_q.push_back(e);
    @(posedge pclk);
    start_req <= 1'b1;
    target_node <= node;
    param_index <= idx;
    rsp_width <= w;
    rsp_data <= d;
    rsp_fail <= f;
    delay <= dly;
    @(posedge pclk);
    param_index <= ~idx;
    target_node <= 8'h00;
    @(negedge pclk);
    if (e.fc != param_read_pkg::FAULT_BAD_NODE) begin
      check(busy, 1);
      check(active, 1);
      check(xfer_node, node);
      check({xfer_index, xfer_subindex}, {idx, 8'h00});
    end
    if (again) begin
      @(posedge pclk);
      start_req <= 1'b0;
      @(posedge pclk);
      start_req <= 1'b1;
    end
    for (n = 0; n < 300 && done !== 1'b1 && error !== 1'b1; n++) @(posedge pclk);
    if (n == 300) begin
      mismatches++;
      final_report();
    end
    repeat (3) @(posedge pclk);
    start_req <= 1'b0;
    @(negedge pclk);
    check(done, !e.err);
    @(negedge pclk);
    check({done, error, fault_code}, 18'h0);
    check({width_code, read_data}, {e.w, e.d});
  endtask : run
  // Each rising done or error takes the oldest expected result off the queue.
  always @(negedge pclk) begin
    if ((done === 1'b1 && !done_q) || (error === 1'b1 && !err_q)) begin
      check(exp_q.size(), 1);
      if (exp_q.size() > 0) begin
        check({error, fault_code}, {exp_q[0].err, exp_q[0].fc});
        check({width_code, read_data}, {exp_q[0].w, exp_q[0].d});
        check({busy, active}, 2'b00);
        void'(exp_q.pop_front());
      end
    end
    done_q = (done === 1'b1);
    err_q = (error === 1'b1);
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, start_req, rsp_fail, done_q, err_q} = '0;
    {paddr, target_node, param_subindex, delay, rsp_width, param_index} = '0;
    {pwdata, rsp_data} = '0;
    seed = 32'h91417822;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, param_read_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, param_read_pkg::OFS_IRQ_MASK, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check(er, 1'b1);
    apb(1'b1, param_read_pkg::OFS_IRQ_MASK, 32'h3);
    apb(1'b0, param_read_pkg::OFS_IRQ_MASK, 32'h0);
    check(rd, 32'h3);
    for (i = 0; i < 3; i++) begin
      rd = $random(seed);
      run(i == 0 ? 8'h01 : i == 1 ? 8'h7f : {1'b0, rd[6:0]} | 8'h01,
          16'h2000 + {4'h0, rd[19:8]}, 8'h01 << i, 1'b0,
          {5'h0, rd[23:21]} | 8'h01, i == 2);
      check(irq, 1'b1);
    end
    run(8'h22, 16'h260a, 8'h02, 1'b0, 8'd20, 1'b1);
    apb(1'b0, param_read_pkg::OFS_IRQ_STAT, 32'h0);
    check(rd, 32'h1);
    @(negedge pclk);
    check(irq, 1'b0);
    run(8'h00, 16'h2001, 8'h02, 1'b0, 8'h00, 1'b0);
    run(8'h80, 16'h2001, 8'h02, 1'b0, 8'h00, 1'b0);
    run(8'h05, 16'h2002, 8'h04, 1'b1, 8'h02, 1'b0);
    run(8'h05, 16'h2003, 8'h03, 1'b0, 8'h01, 1'b0);
    apb(1'b0, param_read_pkg::OFS_IRQ_STAT, 32'h0);
    check(rd, 32'h2);
    apb(1'b1, param_read_pkg::OFS_IRQ_MASK, 32'h0);
    run(8'h09, 16'h2004, 8'h01, 1'b0, 8'h01, 1'b0);
    check(irq, 1'b0);
    apb(1'b0, param_read_pkg::OFS_DATA, 32'h0);
    check(rd, rsp_data & 32'h0000_00ff);
    apb(1'b0, param_read_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h0000_0100);
    final_report();
  end
endmodule : testbench
